// File: hdl/fpe_params.svh
// Constants of the flash program and erase sequencer
`ifndef FPE_PARAMS_SVH
`define FPE_PARAMS_SVH

// Instruction codes
`define FPE_OPC_QUAD_PROG 8'h32
`define FPE_OPC_SECTOR 8'h20
`define FPE_OPC_BLK32 8'h52
`define FPE_OPC_BLK64 8'hd8
`define FPE_OPC_CHIP_A 8'hc7
`define FPE_OPC_CHIP_B 8'h60

// Frame layout in bits
`define FPE_OPC_BITS 5'h08
`define FPE_ADDR_BITS 5'h18
`define FPE_ADDR_W 24
`define FPE_BYTE_W 8
`define FPE_WORD_W 32

// Array geometry as log2 of bytes
`define FPE_PAGE_LOG2 8
`define FPE_SECTOR_LOG2 12
`define FPE_BLK32_LOG2 15
`define FPE_BLK64_LOG2 16
`define FPE_ARRAY_LOG2 22

// Buffering
`define FPE_FIFO_DEPTH 16

// Timing: clock period in ns and self-timed durations in us
`define FPE_CLK_PERIOD_NS 10
`define FPE_NS_PER_US 1000
`define FPE_PAGE_PROG_TIME_US 800
`define FPE_SECTOR_ERASE_TIME_US 100000
`define FPE_SMALL_BLOCK_ERASE_TIME_US 200000
`define FPE_LARGE_BLOCK_ERASE_TIME_US 400000
`define FPE_CHIP_ERASE_TIME_US 10000000

`endif

// File: hdl/fpe_pkg.sv
// Types shared by the flash program and erase sequencer
package fpe_pkg;

    // Link frame decoder states
    typedef enum logic [2:0] {
        ST_OPC = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_END = 3'b011,
        ST_DROP = 3'b100
    } fpe_state_e;

    // Self-timed array operations
    typedef enum logic [2:0] {
        OP_PROG = 3'b000,
        OP_SECT = 3'b001,
        OP_BLK32 = 3'b010,
        OP_BLK64 = 3'b011,
        OP_CHIP = 3'b100
    } fpe_op_e;

    // Protected address range
    typedef struct packed {
        logic any;
        logic [21:0] lo;
        logic [21:0] hi;
    } fpe_range_s;

endpackage

// File: hdl/fpe_fifo_if.sv
// Carrier between the sequencer and its page byte buffer
`timescale 1ns/1ps
`include "fpe_params.svh"

interface fpe_fifo_if #(parameter int WIDTH = `FPE_WORD_W);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic drained;

    modport src (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data, drained);
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, drained);
endinterface

// File: hdl/fpe_fifo.sv
// Page byte buffer with registered output stage
`timescale 1ns/1ps
`include "fpe_params.svh"

module fpe_fifo #(
    parameter int WIDTH = `FPE_WORD_W, // Word width
    parameter int DEPTH = `FPE_FIFO_DEPTH // Entries, power of two
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    fpe_fifo_if.fifo port // Push and pop sides
);
    import fpe_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic relies on wrap at a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fpe_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;
    logic empty;
    logic full;
    logic push;
    logic load;

    // Full when pointers differ only in the wrap bit
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                  (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign push = port.in_valid && !full;
    assign load = !empty && (!out_valid_ff || port.out_ready);
    assign port.in_ready = !full;
    assign port.out_valid = out_valid_ff;
    assign port.out_data = out_data_ff;
    assign port.drained = empty && !out_valid_ff;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= port.in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (load) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

    // Output stage keeps the pop side straight from flops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (load) begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem[rd_ptr_ff[AW-1:0]];
        end else if (port.out_ready) begin
            out_valid_ff <= 1'b0;
        end
    end

    full_refuses_a: assert property (@(posedge clk) disable iff (!reset_n)
        full |-> !port.in_ready ##1 $stable(wr_ptr_ff))
        else $error("buffer took a word while full");

    out_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        out_valid_ff && !port.out_ready |=> out_valid_ff &&
        $stable(out_data_ff))
        else $error("output word changed while stalled");
endmodule

// File: hdl/fpe_top.sv
// Program and erase command sequencer behind the serial flash link
//
// Operation
// - Opcode 32h, 24-bit address, data bytes; address and data on four lines.
// - Quad program accepted only while quad_enable_bit is set.
// - Quad program accepted only while write_enable_latch is set.
// - Quad program writes up to 256 bytes like standard page program.
// - Quad program decoded only in single-line instruction mode.
// - Opcode 20h plus 24-bit address erases the 4K-byte sector.
// - Opcode 52h plus 24-bit address erases the 32K-byte block.
// - Opcode D8h plus 24-bit address erases the 64K-byte block.
// - Opcodes C7h or 60h without address erase the whole array.
// - Any erase needs write_enable_latch set, else it is discarded.
// - Chip select must rise right after last byte's eighth bit.
// - Chip erase needs chip select rising right after opcode bit eight.
// - Valid erase runs a self-timed cycle of its own duration.
// - Busy is one during the cycle, zero after; status reads continue.
// - Cycle completion clears write_enable_latch.
// - Sector or block erase refused when its target is protected.
// - Chip erase refused when any part of the array is protected.
// - Program bytes past page end wrap to the page start.
`timescale 1ns/1ps
`include "fpe_params.svh"

module fpe_top #(
    parameter int FIFO_DEPTH = `FPE_FIFO_DEPTH, // Buffer entries
    parameter longint unsigned PAGE_PROG_TIME_US =
        `FPE_PAGE_PROG_TIME_US, // Program cycle
    parameter longint unsigned SECTOR_ERASE_TIME_US =
        `FPE_SECTOR_ERASE_TIME_US, // Sector erase cycle
    parameter longint unsigned SMALL_BLOCK_ERASE_TIME_US =
        `FPE_SMALL_BLOCK_ERASE_TIME_US, // 32K erase cycle
    parameter longint unsigned LARGE_BLOCK_ERASE_TIME_US =
        `FPE_LARGE_BLOCK_ERASE_TIME_US, // 64K erase cycle
    parameter longint unsigned CHIP_ERASE_TIME_US =
        `FPE_CHIP_ERASE_TIME_US // Chip erase cycle
) (
    input wire logic CLK, // System clock, 100 MHz
    input wire logic RESET_N, // Synchronous reset
    input wire logic CS_N, // Link chip select pin
    input wire logic SCLK, // Link serial clock pin
    input wire logic [3:0] QUAD_LINE_IN, // Link data lines 0 to 3
    input wire logic QPI_MODE, // Four-line instruction mode
    input wire logic WRITE_ENABLE_LATCH, // Latch state
    input wire logic QUAD_ENABLE_BIT, // Quad enable state
    input wire logic PROTECT_COMPLEMENT, // Invert protected area
    input wire logic PROTECT_SMALL_GRANULE, // Sector granule
    input wire logic PROTECT_TOP_BOTTOM, // Protect from bottom
    input wire logic BLOCK_PROTECT_2, // Protect size bit 2
    input wire logic BLOCK_PROTECT_1, // Protect size bit 1
    input wire logic BLOCK_PROTECT_0, // Protect size bit 0
    input wire logic ARR_WR_READY, // Array takes a byte
    output logic BUSY, // Self-timed cycle running
    output logic WRITE_ENABLE_CLEAR, // Pulse: clear latch
    output logic ARR_START, // Pulse: commit operation
    output fpe_pkg::fpe_op_e ARR_OP, // Operation with start
    output logic [`FPE_ADDR_W-1:0] ARR_ADDR, // Aligned unit base
    output logic ARR_DISCARD, // Pulse: drop loaded bytes
    output logic ARR_WR_VALID, // Program byte valid
    output logic [`FPE_WORD_W-1:0] ARR_WR_WORD, // Address and byte
    output logic PROG_OVERRUN // Buffer overflowed
);
    import fpe_pkg::*;

    // Cycle counts derived from the durations, never below one
    localparam longint unsigned NS = `FPE_NS_PER_US;
    localparam longint unsigned PER = `FPE_CLK_PERIOD_NS;
    localparam longint unsigned PP_C = PAGE_PROG_TIME_US * NS / PER;
    localparam longint unsigned SE_C = SECTOR_ERASE_TIME_US * NS / PER;
    localparam longint unsigned B1_C = SMALL_BLOCK_ERASE_TIME_US * NS / PER;
    localparam longint unsigned B2_C = LARGE_BLOCK_ERASE_TIME_US * NS / PER;
    localparam longint unsigned CE_C = CHIP_ERASE_TIME_US * NS / PER;

    if (PP_C < 1 || SE_C < 1 || B1_C < 1 || B2_C < 1 || CE_C < 1 ||
        CE_C > 64'hffffffff) begin : g_chk
        $error("fpe_top: cycle times out of range");
    end

    // Link synchronisers; stage 0 feeds only stage 1
    logic [2:0] cs_sync_ff;
    logic [2:0] sclk_sync_ff;
    logic [3:0] io_s1_ff;
    logic [3:0] io_s2_ff;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cs_sync_ff <= 3'h7;
            sclk_sync_ff <= 3'h0;
            io_s1_ff <= 4'h0;
            io_s2_ff <= 4'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], CS_N};
            sclk_sync_ff <= {sclk_sync_ff[1:0], SCLK};
            io_s1_ff <= QUAD_LINE_IN;
            io_s2_ff <= io_s1_ff;
        end
    end

    logic cs_hi;
    logic cs_rise;
    logic sclk_rise;
    assign cs_hi = cs_sync_ff[1];
    assign cs_rise = cs_sync_ff[1] && !cs_sync_ff[2];
    assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2] && !cs_hi;

    fpe_state_e state_ff;
    fpe_op_e op_ff;
    logic lane4_ff;
    logic [4:0] bits_ff;
    logic [23:0] sh_ff;
    logic [23:0] base_ff;
    logic nib_ff;
    logic [7:0] byte_cnt_ff;
    logic got_byte_ff;
    logic overrun_ff;
    logic busy_ff;
    logic [31:0] timer_ff;

    // Shift by one line or four lines per serial clock
    logic [23:0] sh_nxt;
    logic [4:0] bits_nxt;
    logic [7:0] opcode;
    logic opc_done;
    logic addr_done;
    assign sh_nxt = lane4_ff ? {sh_ff[19:0], io_s2_ff} :
                               {sh_ff[22:0], io_s2_ff[0]};
    assign bits_nxt = bits_ff + (lane4_ff ? 5'h04 : 5'h01);
    assign opcode = sh_nxt[7:0];
    assign opc_done = sclk_rise && state_ff == ST_OPC &&
                      bits_nxt == `FPE_OPC_BITS;
    assign addr_done = sclk_rise && state_ff == ST_ADDR &&
                       bits_nxt == `FPE_ADDR_BITS;

    // Opcode decode with its acceptance checks
    fpe_op_e dec_op;
    fpe_state_e dec_next;
    always_comb begin
        dec_op = OP_PROG;
        dec_next = ST_DROP;
        case (opcode)
            `FPE_OPC_QUAD_PROG: begin
                if (!lane4_ff && QUAD_ENABLE_BIT && WRITE_ENABLE_LATCH) begin
                    dec_next = ST_ADDR;
                end
            end
            `FPE_OPC_SECTOR: begin
                dec_op = OP_SECT;
                dec_next = WRITE_ENABLE_LATCH ? ST_ADDR : ST_DROP;
            end
            `FPE_OPC_BLK32: begin
                dec_op = OP_BLK32;
                dec_next = WRITE_ENABLE_LATCH ? ST_ADDR : ST_DROP;
            end
            `FPE_OPC_BLK64: begin
                dec_op = OP_BLK64;
                dec_next = WRITE_ENABLE_LATCH ? ST_ADDR : ST_DROP;
            end
            `FPE_OPC_CHIP_A, `FPE_OPC_CHIP_B: begin
                dec_op = OP_CHIP;
                dec_next = WRITE_ENABLE_LATCH ? ST_END : ST_DROP;
            end
            default: begin
                dec_next = ST_DROP;
            end
        endcase
        // Other commands stay free for status reads while busy
        if (busy_ff) begin
            dec_next = ST_DROP;
        end
    end

    // Frame state; a rising chip select always restarts decoding
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_ff <= ST_OPC;
        end else if (cs_hi) begin
            state_ff <= ST_OPC;
        end else if (sclk_rise) begin
            case (state_ff)
                ST_OPC: begin
                    if (opc_done) begin
                        state_ff <= dec_next;
                    end
                end
                ST_ADDR: begin
                    if (addr_done) begin
                        state_ff <= (op_ff == OP_PROG) ? ST_DATA : ST_END;
                    end
                end
                ST_DATA: begin
                    state_ff <= ST_DATA;
                end
                ST_END: begin
                    state_ff <= ST_DROP;
                end
                default: begin
                    state_ff <= ST_DROP;
                end
            endcase
        end
    end

    // Shift register, bit count, operation and address capture
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            sh_ff <= 24'h0;
            bits_ff <= 5'h0;
            lane4_ff <= 1'b0;
            op_ff <= OP_PROG;
            base_ff <= 24'h0;
        end else if (cs_hi) begin
            bits_ff <= 5'h0;
            lane4_ff <= QPI_MODE;
        end else if (sclk_rise) begin
            sh_ff <= sh_nxt;
            if (opc_done || addr_done) begin
                bits_ff <= 5'h0;
            end else if (state_ff == ST_OPC || state_ff == ST_ADDR) begin
                bits_ff <= bits_nxt;
            end
            if (opc_done) begin
                op_ff <= dec_op;
                if (opcode == `FPE_OPC_QUAD_PROG) begin
                    lane4_ff <= 1'b1;
                end
            end
            if (addr_done) begin
                base_ff <= sh_nxt;
            end
        end
    end

    // Data nibbles pair into bytes, high nibble first
    logic push_fire;
    assign push_fire = sclk_rise && state_ff == ST_DATA && nib_ff;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            nib_ff <= 1'b0;
            byte_cnt_ff <= 8'h0;
            got_byte_ff <= 1'b0;
        end else if (cs_hi) begin
            nib_ff <= 1'b0;
            byte_cnt_ff <= 8'h0;
            got_byte_ff <= 1'b0;
        end else if (sclk_rise && state_ff == ST_DATA) begin
            nib_ff <= !nib_ff;
            if (nib_ff) begin
                byte_cnt_ff <= byte_cnt_ff + 8'h01;
                got_byte_ff <= 1'b1;
            end
        end
    end

    // Byte address wraps inside the page, overwriting earlier bytes
    logic push_valid_ff;
    logic [`FPE_WORD_W-1:0] push_word_ff;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            push_valid_ff <= 1'b0;
            push_word_ff <= '0;
        end else begin
            push_valid_ff <= push_fire;
            if (push_fire) begin
                push_word_ff <= {base_ff[23:8], base_ff[7:0] + byte_cnt_ff,
                                 sh_nxt[7:0]};
            end
        end
    end

    fpe_fifo_if #(.WIDTH(`FPE_WORD_W)) fifo_bus ();
    assign fifo_bus.in_valid = push_valid_ff;
    assign fifo_bus.in_data = push_word_ff;
    assign fifo_bus.out_ready = ARR_WR_READY;
    assign ARR_WR_VALID = fifo_bus.out_valid;
    assign ARR_WR_WORD = fifo_bus.out_data;

    fpe_fifo #(.WIDTH(`FPE_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .reset_n(RESET_N),
        .port(fifo_bus.fifo)
    );

    // A lost byte would leave a hole, so the program is refused
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            overrun_ff <= 1'b0;
        end else if (push_valid_ff && !fifo_bus.in_ready) begin
            overrun_ff <= 1'b1;
        end else if (opc_done) begin
            overrun_ff <= 1'b0;
        end
    end

    // Protected range from the protect settings
    function automatic fpe_range_s prot_range(input logic cmp,
        input logic sec, input logic tb, input logic [2:0] bp);
        fpe_range_s r;
        int lg;
        logic [21:0] m;
        lg = sec ? `FPE_SECTOR_LOG2 + ((bp > 3'h4) ?
             (`FPE_BLK32_LOG2 - `FPE_SECTOR_LOG2) : int'(bp) - 1) :
             `FPE_BLK64_LOG2 + int'(bp) - 1;
        if (bp == 3'h7) begin
            lg = `FPE_ARRAY_LOG2;
        end
        m = 22'((23'h1 << lg) - 23'h1);
        r.any = (bp != 3'h0);
        r.lo = tb ? 22'h0 : ~m;
        r.hi = tb ? m : 22'h3fffff;
        if (cmp) begin
            if (!r.any) begin
                r = '{any: 1'b1, lo: 22'h0, hi: 22'h3fffff};
            end else if (bp == 3'h7) begin
                r.any = 1'b0;
            end else if (tb) begin
                r = '{any: 1'b1, lo: m + 22'h1, hi: 22'h3fffff};
            end else begin
                r = '{any: 1'b1, lo: 22'h0, hi: ~m - 22'h1};
            end
        end
        return r;
    endfunction

    // Unit span: low address bits below the unit size are ignored
    fpe_range_s prot;
    logic [23:0] unit_mask;
    logic [23:0] unit_lo;
    logic [23:0] unit_hi;
    logic prot_hit;
    always_comb begin
        prot = prot_range(PROTECT_COMPLEMENT, PROTECT_SMALL_GRANULE,
            PROTECT_TOP_BOTTOM,
            {BLOCK_PROTECT_2, BLOCK_PROTECT_1, BLOCK_PROTECT_0});
        case (op_ff)
            OP_SECT: unit_mask = (24'h1 << `FPE_SECTOR_LOG2) - 24'h1;
            OP_BLK32: unit_mask = (24'h1 << `FPE_BLK32_LOG2) - 24'h1;
            OP_BLK64: unit_mask = (24'h1 << `FPE_BLK64_LOG2) - 24'h1;
            OP_CHIP: unit_mask = 24'hffffff;
            default: unit_mask = (24'h1 << `FPE_PAGE_LOG2) - 24'h1;
        endcase
        unit_lo = base_ff & ~unit_mask;
        unit_hi = base_ff | unit_mask;
        prot_hit = prot.any && unit_lo[21:0] <= prot.hi &&
                   unit_hi[21:0] >= prot.lo;
    end

    // Commit only on a chip select rise exactly at a byte boundary
    logic at_boundary;
    logic commit;
    logic discard;
    assign at_boundary = state_ff == ST_END ||
        (state_ff == ST_DATA && !nib_ff && got_byte_ff);
    assign commit = cs_rise && !busy_ff && at_boundary && !prot_hit &&
                    !overrun_ff;
    assign discard = cs_rise && op_ff == OP_PROG && got_byte_ff && !commit;

    // Self-timed cycle; it also waits for the buffer to drain
    logic [31:0] load_cnt;
    logic done;
    always_comb begin
        case (op_ff)
            OP_SECT: load_cnt = 32'(SE_C - 1);
            OP_BLK32: load_cnt = 32'(B1_C - 1);
            OP_BLK64: load_cnt = 32'(B2_C - 1);
            OP_CHIP: load_cnt = 32'(CE_C - 1);
            default: load_cnt = 32'(PP_C - 1);
        endcase
    end
    assign done = busy_ff && timer_ff == 32'h0 && fifo_bus.drained;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            busy_ff <= 1'b0;
            timer_ff <= 32'h0;
        end else if (commit) begin
            busy_ff <= 1'b1;
            timer_ff <= load_cnt;
        end else if (busy_ff) begin
            if (timer_ff != 32'h0) begin
                timer_ff <= timer_ff - 32'h1;
            end else if (done) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // Registered outputs toward the array and status logic
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ARR_START <= 1'b0;
            ARR_OP <= OP_PROG;
            ARR_ADDR <= '0;
            ARR_DISCARD <= 1'b0;
            WRITE_ENABLE_CLEAR <= 1'b0;
        end else begin
            ARR_START <= commit;
            ARR_DISCARD <= discard;
            WRITE_ENABLE_CLEAR <= done;
            if (commit) begin
                ARR_OP <= op_ff;
                ARR_ADDR <= unit_lo;
            end
        end
    end
    assign BUSY = busy_ff;
    assign PROG_OVERRUN = overrun_ff;

    sequence start_s;
        ARR_START;
    endsequence
    sequence end_s;
        $fell(BUSY) ##0 WRITE_ENABLE_CLEAR;
    endsequence

    busy_on_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        start_s |-> BUSY && $rose(BUSY))
        else $error("busy did not rise with start");
    latch_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(BUSY) |-> end_s)
        else $error("latch not cleared at cycle end");
    quad_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        opc_done && opcode == `FPE_OPC_QUAD_PROG &&
        !(QUAD_ENABLE_BIT && WRITE_ENABLE_LATCH && !lane4_ff)
        |=> state_ff == ST_DROP)
        else $error("quad program accepted without its enables");
    erase_wel_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        opc_done && !WRITE_ENABLE_LATCH |=> state_ff == ST_DROP)
        else $error("erase accepted without the latch");
    chip_prot_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        start_s ##0 ARR_OP == OP_CHIP |-> !$past(prot.any))
        else $error("chip erase ran with protection set");
    unit_align_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        start_s ##0 ARR_OP == OP_SECT |-> ARR_ADDR[11:0] == 12'h0)
        else $error("sector base not aligned");
    page_wrap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        push_valid_ff |-> push_word_ff[31:16] == base_ff[23:8])
        else $error("program byte left its page");
    mid_byte_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        cs_rise && state_ff == ST_DATA && nib_ff |=> !ARR_START)
        else $error("started after a split byte");
endmodule

// File: tb/fpe_host.sv
// Host link controller model driving the flash pins
`timescale 1ns/1ps
module fpe_host (
    output logic CS_N = 1'b1, // Chip select, active low
    output logic SCLK = 1'b0, // Link clock, still between frames
    output logic [3:0] QL = 4'h0 // Data lines
);
    // Shift n units MSB first, one line or four per clock
    task automatic send(input logic [63:0] v, input int n, input bit q);
        for (int i = 0; i < n; i++) begin
            QL = q ? v[63-4*i -: 4] : {~QL[3:1], v[63-i]};
            CS_N = 1'b0;
            #62.5 SCLK = 1'b1;
            #62.5 SCLK = 1'b0;
        end
    endtask
    // End frame; released lines no longer show data
    task automatic stop();
        CS_N = 1'b1;
        QL = ~QL;
        #100;
    endtask
endmodule

// File: tb/flash_program_erase_commands_bench.sv
// Self-checking bench of the program and erase sequencer
`timescale 1ns/1ps
`include "fpe_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    miscompares++; $display("Error %0t %h %h", $time, a, b); end end
module flash_program_erase_commands_bench;
    import fpe_pkg::*;
    logic clk = 0, rst_n = 0, qpi = 0, write_enable_latch = 0, qe = 0, rdy = 0;
    logic [5:0] prot = 0;
    logic cs_n, sclk, busy, wec, start, disc, wvalid, ovr;
    logic [3:0] ql;
    fpe_op_e op;
    logic [23:0] addr;
    logic [31:0] word, ew;
    logic [27:0] es, sq[$];
    logic [31:0] wq[$];
    int miscompares = 0, samples_checked = 0, clears = 0, nst = 0;
    int discards = 0, ndisc = 0;
    bit hold = 0;
    logic [31:0] seed = 32'hb64660c0;
    logic [7:0] codes[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    fpe_op_e ops[5] = '{OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP, OP_CHIP};
    logic [23:0] masks[5] = '{24'hfff, 24'h7fff, 24'hffff, '1, '1};
    fpe_top #(.PAGE_PROG_TIME_US(1), .SECTOR_ERASE_TIME_US(1),
        .SMALL_BLOCK_ERASE_TIME_US(1), .LARGE_BLOCK_ERASE_TIME_US(1),
        .CHIP_ERASE_TIME_US(1)) u_fpe_top (.CLK(clk), .RESET_N(rst_n),
        .CS_N(cs_n), .SCLK(sclk), .QUAD_LINE_IN(ql), .QPI_MODE(qpi),
        .WRITE_ENABLE_LATCH(write_enable_latch), .QUAD_ENABLE_BIT(qe),
        .PROTECT_COMPLEMENT(prot[5]), .PROTECT_SMALL_GRANULE(prot[4]),
        .PROTECT_TOP_BOTTOM(prot[3]), .BLOCK_PROTECT_2(prot[2]),
        .BLOCK_PROTECT_1(prot[1]), .BLOCK_PROTECT_0(prot[0]),
        .ARR_WR_READY(rdy), .BUSY(busy), .WRITE_ENABLE_CLEAR(wec),
        .ARR_START(start), .ARR_OP(op), .ARR_ADDR(addr), .ARR_DISCARD(disc),
        .ARR_WR_VALID(wvalid), .ARR_WR_WORD(word), .PROG_OVERRUN(ovr));
    fpe_host u_fpe_host (.CS_N(cs_n), .SCLK(sclk), .QL(ql));
    // Clock
    initial forever #5 clk = ~clk;
    // Scoreboard; an unexpected result meets an unknown note and fails
    always @(posedge clk) begin
        rdy <= $random(seed) & !hold;
        if (wec) clears++;
        if (disc) discards++;
        if (start) begin
            es = sq.size() ? sq.pop_front() : 'x;
            `CHK({busy, op, addr}, es)
        end
        if (wvalid && rdy) begin
            ew = wq.size() ? wq.pop_front() : 'x;
            `CHK(word, ew)
        end
    end
    // Closing report
    task automatic give_verdict(input bit hung);
        if (hung) miscompares++;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // No command while busy; bounded wait
    task automatic idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
        if (busy !== 1'b0) give_verdict(1);
    endtask
    // Status levels change at a clock edge
    task automatic set(input bit w, input bit q, input bit m, input int p);
        @(posedge clk);
        write_enable_latch <= w;
        qe <= q;
        qpi <= m;
        prot <= p[5:0];
    endtask
    task automatic erase(input logic [7:0] c, input logic [23:0] a,
        input int n, input fpe_op_e o, input logic [23:0] m, input bit ok);
        idle();
        u_fpe_host.send({c, a, 32'h0}, n, 0);
        if (ok) sq.push_back({1'b1, o, a & ~m});
        nst += ok;
        u_fpe_host.stop();
    endtask
    // Program; a split byte or a lost byte ends in a discard, not a start
    task automatic prog(input logic [23:0] a, input int nb, input bit ok,
        input bit odd);
        logic [7:0] b;
        bit drop;
        drop = odd || nb > `FPE_FIFO_DEPTH + 1;
        idle();
        u_fpe_host.send({8'h32, 56'h0}, qpi ? 2 : 8, qpi);
        u_fpe_host.send({a, 40'h0}, 6, 1);
        for (int i = 0; i < nb; i++) begin
            b = $random(seed);
            if (ok && i <= `FPE_FIFO_DEPTH)
                wq.push_back({a[23:8], a[7:0] + i[7:0], b});
            u_fpe_host.send({b, 56'h0}, 2, 1);
        end
        if (odd) u_fpe_host.send(64'h0, 1, 1);
        if (ok && !drop) sq.push_back({1'b1, OP_PROG, a[23:8], 8'h00});
        nst += ok && !drop;
        ndisc += ok && drop;
        u_fpe_host.stop();
        if (ok) `CHK(ovr, nb > `FPE_FIFO_DEPTH + 1)
    endtask
    // Main sequence; top 64K protected where protection is 1
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        set(1, 1, 0, 0);
        foreach (codes[k]) erase(codes[k], $random(seed) & 24'h3fffff,
            k < 3 ? 32 : 8, ops[k], masks[k], 1);
        set(0, 1, 0, 0);
        erase(8'h20, 24'h000123, 32, OP_SECT, 24'hfff, 0);
        set(1, 1, 0, 0);
        erase(8'h20, 24'h000123, 36, OP_SECT, 24'hfff, 0);
        erase(8'hc7, 24'h0, 9, OP_CHIP, '1, 0);
        set(1, 1, 0, 1);
        erase(8'hd8, 24'h3f1234, 32, OP_BLK64, 24'hffff, 0);
        erase(8'h60, 24'h0, 8, OP_CHIP, '1, 0);
        erase(8'h20, 24'h001234, 32, OP_SECT, 24'hfff, 1);
        set(1, 1, 0, 0);
        prog(24'h0001fe, 3, 1, 0);
        prog(24'h000300, 1, 1, 1);
        // Array stalled: the buffer overflows and the program is refused
        hold = 1;
        prog(24'h000400, 18, 1, 0);
        hold = 0;
        set(1, 0, 0, 0);
        prog(24'h000200, 2, 0, 0);
        set(0, 1, 0, 0);
        prog(24'h000200, 2, 0, 0);
        set(1, 1, 1, 0);
        prog(24'h000200, 2, 0, 0);
        set(1, 1, 0, 0);
        idle();
        repeat (20) @(posedge clk);
        `CHK(clears, nst)
        `CHK(discards, ndisc)
        `CHK(sq.size() + wq.size(), 0)
        give_verdict(0);
    end
endmodule
